// *** logic/iocf_filter.sv ***
// Per-line input filter: accepts a new level after it stays stable long enough
`default_nettype none
`include "iocf_params.svh"
module iocf_filter
  import iocf_pkg::*;
#(
  parameter int CW = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample,
  input wire logic [CW-1:0] limit,
  output logic level
);

  // Run length of the level that differs from the accepted one
  logic [CW-1:0] cnt;
  // Widened increment so the compare never wraps
  wire logic [CW:0] cnt_inc = {1'b0, cnt} + {{CW{1'b0}}, 1'b1};
  wire logic done = cnt_inc >= {1'b0, limit};

  // Any bounce back to the accepted level restarts the count, so glitches die
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      level <= 1'b0;
    end
    else if (sample == level)
      cnt <= '0;
    else if (done)
    begin
      level <= sample;
      cnt <= '0;
    end
    else
      cnt <= cnt_inc[CW-1:0];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A new level is only taken after a full stable run
  property p_filt_accept;
    $changed(level) |-> ($past(cnt) + 1'b1 >= limit) && ($past(sample) == level);
  endproperty
  a_filt_accept: assert property (p_filt_accept) else $error("filter level changed early");

  // A return to the accepted level clears the run
  property p_filt_restart;
    (sample == level) |=> (cnt == '0);
  endproperty
  a_filt_restart: assert property (p_filt_restart) else $error("filter run not restarted");

endmodule
`default_nettype wire

// *** logic/iocf_params.svh ***
// Constants for the isolated I/O configuration and filter block
`ifndef IOCF_PARAMS_SVH
`define IOCF_PARAMS_SVH

// System clock period in ns (25 MHz)
`define IOCF_CLK_NS 40
// Least detectable pulse width per filter setting, in ns
`define IOCF_FILT_T0_NS 18000
`define IOCF_FILT_T1_NS 36000
`define IOCF_FILT_T2_NS 73000
`define IOCF_FILT_T3_NS 145000
`define IOCF_FILT_T4_NS 290000
`define IOCF_FILT_T5_NS 581000
`define IOCF_FILT_T6_NS 1162000
`define IOCF_FILT_T7_NS 2323000
// Least time to cycles, rounded up
`define IOCF_CYC(t) ((((t) + `IOCF_CLK_NS - 1) / `IOCF_CLK_NS))

// Geometry
`define IOCF_LINES 24
`define IOCF_GROUP_LINES 6
`define IOCF_FIRST_GROUP 8'd2
`define IOCF_LAST_GROUP 8'd5

// Setup word fields
`define IOCF_SU_TYPE_HI 4
`define IOCF_SU_DIR 5
`define IOCF_SU_POL 6

// Line type codes
`define IOCF_TYPE_GP 5'h00
`define IOCF_TYPE_GO 5'h09
`define IOCF_TYPE_DIN_LO 5'h08
`define IOCF_TYPE_DIN_HI 5'h0F
`define IOCF_TYPE_DOUT_LO 5'h10
`define IOCF_TYPE_DOUT_HI 5'h16

// Reset values
`define IOCF_RST_TYPE 5'h00
`define IOCF_RST_DIR 1'b0
`define IOCF_RST_POL 1'b1
`define IOCF_RST_FSEL 3'h7

// Status register bits
`define IOCF_ERR_SETUP 0
`define IOCF_ERR_WRITE 1
`define IOCF_ERR_ADDR 2

// Program line at which a start trigger begins execution
`define IOCF_START_LINE 16'h0001

`endif

// *** logic/iocf_pkg.sv ***
// Types shared by the isolated I/O configuration block
`default_nettype none
package iocf_pkg;
  // Address space, selected by the upper two address bits
  typedef enum logic [1:0] {IOCF_SP_SETUP, IOCF_SP_STATE, IOCF_SP_FILT, IOCF_SP_STAT} iocf_space_e;
  // Line type code
  typedef logic [4:0] iocf_type_t;
endpackage
`default_nettype wire

// *** logic/iocf_top.sv ***
// Isolated I/O line configuration, state mapping and input filtering
`default_nettype none
`include "iocf_params.svh"
module iocf_top
  import iocf_pkg::*;
#(
  // Stable-run lengths in cycles, one per filter setting
  parameter logic [15:0] FILT_CYC_0 = 16'(`IOCF_CYC(`IOCF_FILT_T0_NS)),
  parameter logic [15:0] FILT_CYC_1 = 16'(`IOCF_CYC(`IOCF_FILT_T1_NS)),
  parameter logic [15:0] FILT_CYC_2 = 16'(`IOCF_CYC(`IOCF_FILT_T2_NS)),
  parameter logic [15:0] FILT_CYC_3 = 16'(`IOCF_CYC(`IOCF_FILT_T3_NS)),
  parameter logic [15:0] FILT_CYC_4 = 16'(`IOCF_CYC(`IOCF_FILT_T4_NS)),
  parameter logic [15:0] FILT_CYC_5 = 16'(`IOCF_CYC(`IOCF_FILT_T5_NS)),
  parameter logic [15:0] FILT_CYC_6 = 16'(`IOCF_CYC(`IOCF_FILT_T6_NS)),
  parameter logic [15:0] FILT_CYC_7 = 16'(`IOCF_CYC(`IOCF_FILT_T7_NS))
)
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [23:0] IO_IN,
  output logic [23:0] IO_OUT,
  output logic [23:0] IO_OE,
  input wire logic [6:0] FUNC_OUT,
  output logic [7:0] FUNC_IN,
  output logic PROG_START,
  output logic [15:0] START_LINE
);

  localparam int NL = `IOCF_LINES;
  localparam int GL = `IOCF_GROUP_LINES;

  // Number is a line (N1..N6) or group (N0) of groups 2..5
  function automatic logic num_ok(input logic [7:0] n);
    logic [7:0] t;
    logic [7:0] u;
    t = n / 8'd10;
    u = n % 8'd10;
    return (t >= `IOCF_FIRST_GROUP) && (t <= `IOCF_LAST_GROUP) && (u <= 8'd6);
  endfunction

  // Group index 0..3 of a line or group number
  function automatic logic [1:0] num_grp(input logic [7:0] n);
    logic [7:0] t;
    t = n / 8'd10 - `IOCF_FIRST_GROUP;
    return t[1:0];
  endfunction

  // Member position 0..6, zero for a whole group
  function automatic logic [2:0] num_unit(input logic [7:0] n);
    logic [7:0] u;
    u = n % 8'd10;
    return u[2:0];
  endfunction

  // Type code classes
  function automatic logic is_din(input iocf_type_t t);
    return (t >= `IOCF_TYPE_DIN_LO) && (t <= `IOCF_TYPE_DIN_HI);
  endfunction

  function automatic logic is_dout(input iocf_type_t t);
    return (t >= `IOCF_TYPE_DOUT_LO) && (t <= `IOCF_TYPE_DOUT_HI);
  endfunction

  // Stable-run length for a filter setting
  function automatic logic [15:0] filt_cyc(input logic [2:0] s);
    logic [15:0] c;
    c = FILT_CYC_7;
    case (s)
      3'h0: c = FILT_CYC_0;
      3'h1: c = FILT_CYC_1;
      3'h2: c = FILT_CYC_2;
      3'h3: c = FILT_CYC_3;
      3'h4: c = FILT_CYC_4;
      3'h5: c = FILT_CYC_5;
      3'h6: c = FILT_CYC_6;
      default: c = FILT_CYC_7;
    endcase
    return c;
  endfunction

  // Per-line configuration
  iocf_type_t lt_type [NL];
  logic [NL-1:0] lt_dir;
  logic [NL-1:0] lt_pol;
  // Per-group filter select
  logic [2:0] fsel [4];
  // Latched general purpose output states
  logic [NL-1:0] out_val;
  // Sticky error flags
  logic [2:0] err;
  // Pin synchroniser and filter output
  logic [NL-1:0] pin_s1;
  logic [NL-1:0] pin_s2;
  logic [NL-1:0] filt;
  // Logical states, one cycle old, for start-trigger edges
  logic [NL-1:0] st_q;

  // Address decode
  iocf_space_e sp;
  logic [7:0] num;
  logic addr_ok;
  logic [1:0] grp_a;
  logic [2:0] unit_a;
  logic is_grp_a;
  logic [4:0] idx_a;
  assign sp = iocf_space_e'(ADDR[9:8]);
  assign num = ADDR[7:0];
  assign addr_ok = num_ok(num);
  assign grp_a = num_grp(num);
  assign unit_a = num_unit(num);
  assign is_grp_a = (unit_a == 3'h0);
  // Group base widened before the product, so groups 40 and 50 do not wrap
  assign idx_a = 5'(grp_a) * 5'd6 + (is_grp_a ? 5'h00 : 5'(unit_a - 3'h1));

  // Setup word fields
  iocf_type_t su_type;
  logic su_dir;
  logic su_pol;
  logic su_ok;
  assign su_type = WDATA[`IOCF_SU_TYPE_HI:0];
  assign su_dir = WDATA[`IOCF_SU_DIR];
  assign su_pol = WDATA[`IOCF_SU_POL];
  // Dedicated functions must agree with their inherent direction
  assign su_ok = (su_type == `IOCF_TYPE_GP) || (is_din(su_type) && !su_dir) ||
                 (is_dout(su_type) && su_dir);

  // Per-line combinational view
  logic [NL-1:0] sel;
  logic [NL-1:0] gpout;
  logic [NL-1:0] outl;
  logic [NL-1:0] st;
  logic [NL-1:0] goin;
  logic [NL-1:0] wbit;
  logic [7:0] next_func_in;

  // Line state mapping, selection and dedicated function routing
  always_comb
  begin
    next_func_in = 8'h00;
    for (int i = 0; i < NL; i++)
    begin
      sel[i] = addr_ok && (is_grp_a ? (2'(i / GL) == grp_a) : (5'(i) == idx_a));
      gpout[i] = (lt_type[i] == `IOCF_TYPE_GP) && lt_dir[i];
      // Dedicated outputs follow the motion core's function levels
      if (is_dout(lt_type[i]))
        outl[i] = FUNC_OUT[3'(lt_type[i] - `IOCF_TYPE_DOUT_LO)];
      else
        outl[i] = out_val[i];
      // Inputs: XNOR with polarity gives 1 for high pin when active high
      st[i] = lt_dir[i] ? outl[i] : (filt[i] ~^ lt_pol[i]);
      goin[i] = (lt_type[i] == `IOCF_TYPE_GO) && !lt_dir[i];
      wbit[i] = is_grp_a ? WDATA[i % GL] : WDATA[0];
      if (is_din(lt_type[i]) && !lt_dir[i])
        next_func_in[3'(lt_type[i] - `IOCF_TYPE_DIN_LO)] = 1'b1 & st[i] |
          next_func_in[3'(lt_type[i] - `IOCF_TYPE_DIN_LO)];
    end
  end

  // Write qualification
  logic wr_setup;
  logic wr_state;
  logic wr_filt;
  logic wr_stat;
  logic state_ok;
  logic filt_ok;
  logic [2:0] err_set;
  assign filt_ok = (num >= `IOCF_FIRST_GROUP) && (num <= `IOCF_LAST_GROUP);
  assign wr_setup = WR && (sp == IOCF_SP_SETUP) && addr_ok;
  assign wr_state = WR && (sp == IOCF_SP_STATE) && addr_ok;
  assign wr_filt = WR && (sp == IOCF_SP_FILT) && filt_ok;
  assign wr_stat = WR && (sp == IOCF_SP_STAT) && (num == 8'h00);
  // A group write is taken only when every member is a general purpose output
  assign state_ok = &(~sel | gpout);
  assign err_set[`IOCF_ERR_SETUP] = wr_setup && !su_ok;
  assign err_set[`IOCF_ERR_WRITE] = wr_state && !state_ok;
  assign err_set[`IOCF_ERR_ADDR] = WR && !(wr_setup || wr_state || wr_filt || wr_stat);

  // Line configuration; a group write loads all six members
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < NL; i++)
        lt_type[i] <= `IOCF_RST_TYPE;
      lt_dir <= {NL{`IOCF_RST_DIR}};
      lt_pol <= {NL{`IOCF_RST_POL}};
    end
    else if (wr_setup && su_ok)
    begin
      for (int i = 0; i < NL; i++)
        if (sel[i])
        begin
          lt_type[i] <= su_type;
          lt_dir[i] <= su_dir;
          lt_pol[i] <= su_pol;
        end
    end
  end

  // General purpose output latches; refused writes leave them untouched
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      out_val <= '0;
    else if (wr_state && state_ok)
      out_val <= (out_val & ~sel) | (wbit & sel);
  end

  // Group filter selectors
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int g = 0; g < 4; g++)
        fsel[g] <= `IOCF_RST_FSEL;
    end
    else if (wr_filt)
      fsel[2'(num - `IOCF_FIRST_GROUP)] <= WDATA[2:0];
  end

  // Sticky errors: write one to clear, a new error in the same cycle wins
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      err <= 3'h0;
    else
      err <= (err & ~(wr_stat ? WDATA[2:0] : 3'h0)) | err_set;
  end

  // Two-flop synchroniser on the isolated pins
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= IO_IN;
      pin_s2 <= pin_s1;
    end
  end

  // One filter per line, run length chosen by its group
  for (genvar i = 0; i < NL; i++)
  begin : g_line
    iocf_filter #(.CW(16)) u_filt (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .sample(pin_s2[i]),
      .limit(filt_cyc(fsel[i / GL])),
      .level(filt[i])
    );
  end

  // Pin drive: polarity applied on the way out, enable while an output
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      IO_OUT <= '0;
      IO_OE <= '0;
    end
    else
    begin
      IO_OUT <= outl ~^ lt_pol;
      IO_OE <= lt_dir;
    end
  end

  // Start trigger: rising logical state on a type nine input
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_q <= '0;
      PROG_START <= 1'b0;
      START_LINE <= `IOCF_START_LINE;
      FUNC_IN <= 8'h00;
    end
    else
    begin
      st_q <= st;
      PROG_START <= |(goin & st & ~st_q);
      START_LINE <= `IOCF_START_LINE;
      FUNC_IN <= next_func_in;
    end
  end

  // Read mux; unmapped addresses read zero
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (sp)
      IOCF_SP_SETUP:
        if (addr_ok)
          next_rdata = {1'b0, lt_pol[idx_a], lt_dir[idx_a], lt_type[idx_a]};
      IOCF_SP_STATE:
        if (addr_ok)
          next_rdata = is_grp_a ? {2'b00, 6'(st >> idx_a)} : {7'h00, st[idx_a]};
      IOCF_SP_FILT:
        if (filt_ok)
          next_rdata = {5'h00, fsel[2'(num - `IOCF_FIRST_GROUP)]};
      IOCF_SP_STAT:
        if (num == 8'h00)
          next_rdata = {5'h00, err};
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      RDATA <= 8'h00;
    else
      RDATA <= RD ? next_rdata : 8'h00;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  property p_map_high;
    (!lt_dir[0] && lt_pol[0]) |-> (st[0] == filt[0]);
  endproperty
  a_map_high: assert property (p_map_high) else $error("active high map wrong");

  property p_map_low;
    (!lt_dir[12] && !lt_pol[12]) |-> (st[12] == !filt[12]);
  endproperty
  a_map_low: assert property (p_map_low) else $error("active low map wrong");

  property p_setup_reject;
    (wr_setup && !su_ok) |=> err[`IOCF_ERR_SETUP] && $stable(lt_dir) && $stable(lt_pol);
  endproperty
  a_setup_reject: assert property (p_setup_reject) else $error("bad setup not rejected");

  property p_group_setup;
    (wr_setup && su_ok && is_grp_a && grp_a == 2'h0) |=>
      (lt_type[0] == lt_type[5]) && (lt_dir[5:0] == {6{lt_dir[0]}});
  endproperty
  a_group_setup: assert property (p_group_setup) else $error("group setup not applied");

  property p_write_refuse;
    (wr_state && !state_ok) |=> err[`IOCF_ERR_WRITE] && $stable(out_val);
  endproperty
  a_write_refuse: assert property (p_write_refuse) else $error("refused write took effect");

  sequence s_go_rise;
    goin[18] && st[18] && !st_q[18];
  endsequence
  property p_go_start;
    s_go_rise |=> PROG_START && (START_LINE == `IOCF_START_LINE);
  endproperty
  a_go_start: assert property (p_go_start) else $error("start trigger missed");

  property p_group_read;
    (RD && sp == IOCF_SP_STATE && addr_ok && is_grp_a && grp_a == 2'h1) |=>
      (RDATA == {2'b00, $past(st[11:6])});
  endproperty
  a_group_read: assert property (p_group_read) else $error("group read order wrong");

  property p_filt_limit;
    (fsel[3] == 3'h3) |-> (g_line[18].u_filt.limit == FILT_CYC_3);
  endproperty
  a_filt_limit: assert property (p_filt_limit) else $error("filter length wrong");

  property p_reset_fsel;
    $rose(RESET_N) |-> (fsel[0] == `IOCF_RST_FSEL) && (lt_pol[0] == `IOCF_RST_POL);
  endproperty
  a_reset_fsel: assert property (p_reset_fsel) else $error("reset defaults wrong");

endmodule
`default_nettype wire

// *** sim/iocf_field.sv ***
// Field-side model: sensors on undriven lines, loads reading back driven lines
`default_nettype none
module iocf_field
(
  input wire logic [23:0] drive,
  input wire logic [23:0] enable,
  output logic [23:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels that the switches and sensors put on undriven lines
  logic [23:0] sense = 24'h000000;
  // A line the block drives shows the block's level, never the sensor's
  assign pins = (enable & drive) | (~enable & sense);
  // Sensors change only when the bench says so, off the sampling edge
  task automatic set(input logic [23:0] v);
    sense <= v;
  endtask
endmodule
`default_nettype wire

// *** sim/iocf_top_bench.sv ***
// Self-checking bench for the isolated I/O configuration and filter block
`default_nettype none
module iocf_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_n = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [6:0] fo = 7'h00;
  wire logic [7:0] rdata;
  wire logic [23:0] pins;
  wire logic [23:0] io_out;
  wire logic [23:0] io_oe;
  wire logic [7:0] func_in;
  wire logic prog_start;
  wire logic [15:0] start_line;
  int bad_count = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h99c9;
  // Settings 0..2 keep their true run (pulse width over 40 ns); 3..7 are cut to k+2 cycles
  int lim[8] = '{450, 900, 1825, 5, 6, 7, 8, 9};
  iocf_top #(.FILT_CYC_3(16'h5), .FILT_CYC_4(16'h6), .FILT_CYC_5(16'h7),
    .FILT_CYC_6(16'h8), .FILT_CYC_7(16'h9)) dut (
    .CLOCK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .IO_IN(pins), .IO_OUT(io_out), .IO_OE(io_oe), .FUNC_OUT(fo),
    .FUNC_IN(func_in), .PROG_START(prog_start), .START_LINE(start_line));
  iocf_field field (.drive(io_out), .enable(io_oe), .pins(pins));
  // Free-running 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Xorshift source with a fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Line number of pin bit i, as the model sees it
  function automatic logic [9:0] ln(int i);
    return 10'((i / 6 + 2) * 10 + i % 6 + 1);
  endfunction
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // One-cycle read; data stands only in the following cycle
  task automatic rdc(input logic [9:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk_reg(n, e, rdata);
  endtask
  // Set the sensor levels of group 50 only
  task automatic set50(input logic [5:0] b);
    field.set({b, field.sense[17:0]});
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well over twice the roughly 7400 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("FAIL watchdog expected finish seen hang");
    finish_test();
  end
  initial
  begin
    logic [31:0] r;
    logic [23:0] v;
    int seen;
    logic [7:0] vals[4];
    logic [9:0] ea[3];
    logic [7:0] ed[3];
    logic [7:0] es[3];
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset setup of every line and filter of every group
    for (int k = 0; k < 24; k++)
      rdc(ln(k), 8'h40, "setup");
    for (int g = 2; g < 6; g++)
      rdc(10'h200 + 10'(g), 8'h07, "filter");
    chk_pin("start line", 24'h000001, {8'h00, start_line});
    $display("reset test done");
    // Group 20 as general purpose outputs, active low
    wr(10'h014, 8'h20);
    repeat (2) @(posedge clk);
    chk_pin("oe", 24'h00003F, io_oe);
    r = rnd();
    vals = '{8'd35, 8'd7, 8'd49, {2'b00, r[5:0]}};
    foreach (vals[i])
    begin
      wr(10'h114, vals[i]);
      repeat (3) @(posedge clk);
      chk_pin("group out", {18'h0, ~vals[i][5:0]}, io_out & 24'h3F);
      rdc(10'h114, vals[i], "group state");
    end
    wr(10'h115, 8'h00);
    rdc(10'h114, {2'b00, vals[3][5:1], 1'b0}, "line state");
    $display("output test done");
    // Group 30 active high, group 40 active low, both on the short setting 3
    wr(10'h028, 8'h00);
    wr(10'h203, 8'h03);
    wr(10'h204, 8'h03);
    for (int n = 0; n < 4; n++)
    begin
      r = rnd();
      v = r[23:0] & 24'h03FFC0;
      field.set(v);
      repeat (20) @(posedge clk);
      rdc(10'h11E, {2'b00, v[11:6]}, "high state");
      rdc(10'h128, {2'b00, ~v[17:12]}, "low state");
    end
    $display("input test done");
    // Every filter setting on group 50: short glitch rejected, held level taken
    for (int k = 0; k < 8; k++)
    begin
      wr(10'h205, 8'(k));
      rdc(10'h205, 8'(k), "filter select");
      set50(6'h3F);
      repeat (k + 1) @(posedge clk);
      set50(6'h00);
      repeat (15) @(posedge clk);
      rdc(10'h132, 8'h00, "glitch");
      set50(6'h3F);
      repeat (lim[k] + 8) @(posedge clk);
      rdc(10'h132, 8'h3F, "held level");
      set50(6'h00);
      repeat (lim[k] + 8) @(posedge clk);
    end
    $display("filter test done");
    // Refused setups and writes raise their status bits
    ea = '{10'h01F, 10'h11E, 10'h00A};
    ed = '{8'h10, 8'h01, 8'h00};
    es = '{8'h01, 8'h02, 8'h04};
    foreach (ea[i])
    begin
      wr(ea[i], ed[i]);
      rdc(10'h300, es[i], "status");
      wr(10'h300, 8'h07);
      rdc(10'h300, 8'h00, "status clear");
    end
    rdc(10'h01F, 8'h40, "setup kept");
    $display("error test done");
    // Program start trigger on line 51
    wr(10'h205, 8'h03);
    wr(10'h033, 8'h49);
    set50(6'h01);
    seen = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      if (prog_start === 1'b1)
        seen++;
    end
    chk_reg("start pulses", 8'h01, 8'(seen));
    set50(6'h00);
    // Each dedicated input on line 52 and output on line 53
    for (int k = 0; k < 8; k++)
    begin
      wr(10'h034, 8'h48 + 8'(k));
      if (k < 7)
        wr(10'h035, 8'h70 + 8'(k));
      fo <= 7'(1 << k);
      set50(6'h02);
      repeat (20) @(posedge clk);
      chk_pin("func in", 24'(1 << k), {16'h0, func_in});
      if (k < 7)
        chk_pin("func out", 24'h100000, io_out & 24'h100000);
      set50(6'h00);
      repeat (20) @(posedge clk);
    end
    $display("function test done");
    finish_test();
  end
endmodule
`default_nettype wire
